// [src/jidbp_path.v]
// Purpose: tap with identification and bypass data paths, forced-one quirk
// Assumes: tck/tms/tdi are asynchronous pins sampled by clk (10 MHz)
// Notes:   tck must be slower than clk/4; other instructions act as bypass
//          tdo is released outside shift states; the line needs a pull-up
//          tms high for five tck rises always returns to reset
//
// Notes on behaviour
// - idcode shift takes constant one, not tdi
// - upstream data lost, downstream gets all ones
// - test-logic-reset makes idcode current instruction
// - bypass selects one-bit bypass register path
// - id contents shift out on tdo first
`timescale 1ns/1ns
`default_nettype none
`include "jidbp_defines.vh"

module jidbp_path #(
    parameter IR_W = `JIDBP_IR_WIDTH,
    parameter ID_W = `JIDBP_ID_WIDTH,
    parameter [`JIDBP_ID_WIDTH-1:0] ID_VALUE = `JIDBP_ID_VALUE
) (
    input  wire clk,
    input  wire reset_n,
    input  wire tck,
    input  wire tms,
    input  wire tdi,
    output reg  tdo,
    output reg  tdo_en_n,
    output reg  id_selected
);

    // two-stage synchronisers for the pins
    reg [2:0] sync_a;
    reg [2:0] sync_b;
    reg       tck_prev;
    wire      tck_s = sync_b[2];
    wire      tms_s = sync_b[1];
    wire      tdi_s = sync_b[0];
    wire      tck_rise = tck_s & ~tck_prev;
    wire      tck_fall = ~tck_s & tck_prev;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a   <= 3'h0;
            sync_b   <= 3'h0;
            tck_prev <= 1'b0;
        end else begin
            sync_a   <= {tck, tms, tdi};
            sync_b   <= sync_a;
            tck_prev <= tck_s;
        end
    end

    // tap state codes, binary, shared with the header so the bench
    // and the design agree on the encoding
    localparam [3:0] ST_RESET  = `JIDBP_ST_RESET;
    localparam [3:0] ST_IDLE   = `JIDBP_ST_IDLE;
    localparam [3:0] ST_SEL_DR = `JIDBP_ST_SEL_DR;
    localparam [3:0] ST_CAP_DR = `JIDBP_ST_CAP_DR;
    localparam [3:0] ST_SH_DR  = `JIDBP_ST_SH_DR;
    localparam [3:0] ST_EX1_DR = `JIDBP_ST_EX1_DR;
    localparam [3:0] ST_PAU_DR = `JIDBP_ST_PAU_DR;
    localparam [3:0] ST_EX2_DR = `JIDBP_ST_EX2_DR;
    localparam [3:0] ST_UPD_DR = `JIDBP_ST_UPD_DR;
    localparam [3:0] ST_SEL_IR = `JIDBP_ST_SEL_IR;
    localparam [3:0] ST_CAP_IR = `JIDBP_ST_CAP_IR;
    localparam [3:0] ST_SH_IR  = `JIDBP_ST_SH_IR;
    localparam [3:0] ST_EX1_IR = `JIDBP_ST_EX1_IR;
    localparam [3:0] ST_PAU_IR = `JIDBP_ST_PAU_IR;
    localparam [3:0] ST_EX2_IR = `JIDBP_ST_EX2_IR;
    localparam [3:0] ST_UPD_IR = `JIDBP_ST_UPD_IR;

    // true in the two shift states, where tdo is driven
    function is_shift_state;
        input [3:0] st;
        begin
            is_shift_state = (st == ST_SH_DR) || (st == ST_SH_IR);
        end
    endfunction

    // instruction decode; every other code falls back to bypass
    function insn_is_id;
        input [IR_W-1:0] insn;
        begin
            insn_is_id = (insn == `JIDBP_INSN_IDCODE);
        end
    endfunction

    // tap controller state
    reg [3:0] state;
    reg [3:0] next_state;

    // next-state decode, tms sampled at each tck rise
    always @* begin
        case (state)
            ST_RESET:  next_state = tms_s ? ST_RESET
                                          : ST_IDLE;
            ST_IDLE:   next_state = tms_s ? ST_SEL_DR
                                          : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR
                                          : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR
                                          : ST_SH_DR;
            ST_SH_DR:  next_state = tms_s ? ST_EX1_DR
                                          : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s ? ST_UPD_DR
                                          : ST_PAU_DR;
            ST_PAU_DR: next_state = tms_s ? ST_EX2_DR
                                          : ST_PAU_DR;
            ST_EX2_DR: next_state = tms_s ? ST_UPD_DR
                                          : ST_SH_DR;
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR
                                          : ST_IDLE;
            ST_SEL_IR: next_state = tms_s ? ST_RESET
                                          : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR
                                          : ST_SH_IR;
            ST_SH_IR:  next_state = tms_s ? ST_EX1_IR
                                          : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s ? ST_UPD_IR
                                          : ST_PAU_IR;
            ST_PAU_IR: next_state = tms_s ? ST_EX2_IR
                                          : ST_PAU_IR;
            ST_EX2_IR: next_state = tms_s ? ST_UPD_IR
                                          : ST_SH_IR;
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR
                                          : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    // shift registers and instruction
    reg [IR_W-1:0] ir_shift;
    reg [IR_W-1:0] ir_cur;
    reg [ID_W-1:0] id_shift;
    reg            byp_bit;
    reg            next_tdo;
    reg            next_tdo_en_n;
    wire           is_id = insn_is_id(ir_cur);
    // forced one replaces tdi while the id register is shifted
    wire           id_in = 1'b1;

    // tap state advances on each detected tck rise
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            state <= ST_RESET;
        else if (tck_rise)
            state <= next_state;
    end

    // instruction register; reset entry forces idcode at once
    // so the id register is selected from the first scan on
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_cur   <= `JIDBP_INSN_IDCODE;
            ir_shift <= {IR_W{1'b0}};
        end else if (tck_rise) begin
            if (next_state == ST_RESET)
                ir_cur <= `JIDBP_INSN_IDCODE;
            else if (state == ST_UPD_IR)
                ir_cur <= ir_shift;
            if (state == ST_CAP_IR)
                ir_shift <= {{(IR_W-1){1'b0}}, 1'b1};
            else if (state == ST_SH_IR)
                ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
        end
    end

    // data registers: capture, then one bit per tck rise
    // the id path never sees tdi, which drops upstream data
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            id_shift <= {ID_W{1'b0}};
            byp_bit  <= 1'b0;
        end else if (tck_rise) begin
            if (state == ST_CAP_DR) begin
                if (is_id)
                    id_shift <= ID_VALUE;
                byp_bit <= 1'b0;
            end else if (state == ST_SH_DR) begin
                if (is_id)
                    id_shift <= {id_in, id_shift[ID_W-1:1]};
                else
                    byp_bit <= tdi_s;
            end
        end
    end

    // next tdo: updated on tck fall, driven only in shift states
    // holding between falls keeps tdo stable across the tck rise
    always @* begin
        next_tdo      = tdo;
        next_tdo_en_n = tdo_en_n;
        if (tck_fall) begin
            next_tdo_en_n = ~is_shift_state(state);
            if (state == ST_SH_IR)
                next_tdo = ir_shift[0];
            else if (state == ST_SH_DR)
                next_tdo = is_id ? id_shift[0] : byp_bit;
        end
    end

    // output flops; every port comes straight from a register
    // id_selected lags the instruction by one clk
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo         <= 1'b0;
            tdo_en_n    <= 1'b1;
            id_selected <= 1'b1;
        end else begin
            tdo         <= next_tdo;
            tdo_en_n    <= next_tdo_en_n;
            id_selected <= is_id;
        end
    end

endmodule
`default_nettype wire

// [src/jidbp_defines.vh]
// Purpose: constants for the identification / bypass scan path
// Assumes: included by bare name from the design file
// Notes:   instruction codes and widths are local choices
`ifndef JIDBP_DEFINES_VH
`define JIDBP_DEFINES_VH

`define JIDBP_IR_WIDTH     4
`define JIDBP_ID_WIDTH     32
`define JIDBP_INSN_IDCODE  4'h1
`define JIDBP_INSN_BYPASS  4'hF
// arbitrary neutral identification value
`define JIDBP_ID_VALUE     32'h0000_1001

// tap state codes
`define JIDBP_ST_RESET     4'h0
`define JIDBP_ST_IDLE      4'h1
`define JIDBP_ST_SEL_DR    4'h2
`define JIDBP_ST_CAP_DR    4'h3
`define JIDBP_ST_SH_DR     4'h4
`define JIDBP_ST_EX1_DR    4'h5
`define JIDBP_ST_PAU_DR    4'h6
`define JIDBP_ST_EX2_DR    4'h7
`define JIDBP_ST_UPD_DR    4'h8
`define JIDBP_ST_SEL_IR    4'h9
`define JIDBP_ST_CAP_IR    4'hA
`define JIDBP_ST_SH_IR     4'hB
`define JIDBP_ST_EX1_IR    4'hC
`define JIDBP_ST_PAU_IR    4'hD
`define JIDBP_ST_EX2_IR    4'hE
`define JIDBP_ST_UPD_IR    4'hF

`endif

// [tb/jidbp_props.sv]
// Purpose: port checks  Assumes: slow tck  Notes: bind at foot
`timescale 1ns/1ns
`default_nettype none
module jidbp_props (input wire logic clk, reset_n, tck, tms, tdi,
    input wire logic tdo, tdo_en_n, id_selected);
    logic [2:0] ones;
    // tms-high run at tck rises, held at five
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n) ones <= 3'h0;
        else if ($rose(tck)) ones <= tms ? ones + 3'(ones != 3'h5) : 3'h0;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_tlr; ones == 3'h5; endsequence
    a_rst_id: assert property ($rose(reset_n) |-> id_selected)
        else $error("id not selected after reset");
    a_tlr_id: assert property (s_tlr |-> ##[1:8] id_selected)
        else $error("id not selected after tms run");
    a_insn_rise: assert property ($fell(id_selected) |-> $past(tck, 2))
        else $error("insn changed in tck low");
    a_tdo_low: assert property ($changed(tdo) |-> !tck)
        else $error("tdo changed in tck high");
    a_drive_low: assert property ($fell(tdo_en_n) |-> !tck)
        else $error("drive began in tck high");
    a_drive_hold: assert property ($fell(tdo_en_n) |=> !tdo_en_n [*3])
        else $error("drive dropped early");
endmodule
bind jidbp_path jidbp_props jidbp_props_inst (.clk(clk), .reset_n(reset_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_en_n(tdo_en_n),
    .id_selected(id_selected));
`default_nettype wire

// [tb/jidbp_chain.sv]
// Purpose: chain controller  Assumes: 800 ns tck  Notes: tck rests low
`timescale 1ns/1ns
`default_nettype none
module jidbp_chain (input wire logic clk, tdo, output var logic tck, tms, tdi);
    initial {tck, tms, tdi} = 3'h2;
    // one tck period; lone device, no downstream traffic
    task automatic step(input logic m, d, output logic q);
        {tms, tdi} <= {m, d};
        repeat (4) @(posedge clk);
        tck <= 1'h1;
        repeat (2) @(posedge clk);
        q = tdo;
        repeat (2) @(posedge clk);
        tck <= 1'h0;
    endtask
endmodule
`default_nettype wire

// [tb/jidbp_path_tb_top.sv]
// Purpose: bench  Assumes: 100 ns clk  Notes: expected vectors from rules
`timescale 1ns/1ns
`default_nettype none
`include "jidbp_defines.vh"
module jidbp_path_tb_top;
    logic clk = 1'h0, reset_n = 1'h0;
    wire tck, tms, tdi, tdo, tdo_en_n, id_selected;
    // released line pulled high, as on the board
    wire tdo_line = tdo_en_n ? 1'b1 : tdo;
    int bad_count = 0, comparisons = 0;
    logic [63:0] seen, rnd = 64'($urandom(32'h936c_7abb));
    always #50 clk = ~clk;
    jidbp_path jidbp_path_inst (.*);
    jidbp_chain jidbp_chain_inst (.*, .tdo(tdo_line));
    task automatic check(input logic [63:0] got, exp);
        comparisons++;
        if (got !== exp) $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
        bad_count += int'(got !== exp);
    endtask
    task automatic scan(input int n, input logic [63:0] m, d);
        for (int i = 0; i < n; i++) jidbp_chain_inst.step(m[i], d[i], seen[i]);
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // id read, bypass load and pass-through, tms-high reset
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        for (int t = 0; t < 2; t++) begin
            check(id_selected, 1'h1);
            rnd = {$urandom, $urandom};
            scan(46, 64'h0000_1800_0000_0002, rnd);
            check(seen[43:4], {8'hFF, `JIDBP_ID_VALUE});
            check(seen[45:44], 2'h3);
            scan(10, 64'h0000_0000_0000_0183, 64'h0000_0000_0000_00F0);
            check({seen[7:4], id_selected}, 5'h02);
            scan(40, 64'h0000_00FC_0000_0001, rnd);
            check(seen[34:3], {rnd[33:3], 1'h0});
            $display("round %0d done", t);
        end
        give_verdict();
    end
    // hang guard
    initial begin
        #400000 bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
